// *** mecsi_top.sv ***
// MAC to Manchester codec serial interface with internal codec and APB.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// RL1 - Internal carrier rises on first line fall, holds 1.5 bits past data.
// RL2 - Select 0 feeds MAC from internal codec; 1 from external codec inputs.
// RL3 - Internal codec signals are driven onto their pins for observation.
// RL4 - External codec drives carrier input high while valid data arrives.
// RL5 - Internal collision output is high while the collision tone is seen.
// RL6 - Collision is watched from the frame delimiter to the frame end.
// RL7 - After transmission the collision input is checked for heartbeat.
// RL8 - Internal receive data is sampled on the recovered clock rising edge.
// RL9 - External codec gives data and clock; MAC captures on clock rise.
// RL10 - Recovered receive clock runs five bit times after carrier falls.
// RL11 - Transmit data changes so each bit is valid at transmit clock rise.
// RL12 - Transmit enable rises at transmit start, holds until last byte.
// RL13 - Shared data and clock pins stay undriven until configuration write.
// RL14 - Extended option makes shared pins user outputs once bus master.
// RL15 - Internal transmit clock is the oscillator halved; external supplied.
// RL16 - Link inputs are synchronised to the system clock before use.
module mecsi_top (
  // System
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 busMaster,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic                      irq,
  // Line side of the internal codec
  input  wire logic                 rxLine,
  input  wire logic                 collisionPair,
  input  wire logic                 oscIn,
  // Codec pins: link inputs, driven pins each with a value and enable, and transmit enable
  input  wire logic                 carrier_sense_in,
  input  wire logic                 collision_in,
  input  wire logic                 rx_nrz_in,
  input  wire logic                 rx_clock_in,
  input  wire logic                 tx_clock_in,
  output mecsi_pkg::mecsi_pin_t     carrierPin,
  output mecsi_pkg::mecsi_pin_t     collisionPin,
  output mecsi_pkg::mecsi_pin_t     txClockPin,
  output mecsi_pkg::mecsi_pin_t [3:0] sharedPin,
  output logic                      tx_enable
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [mecsi_pkg::N_SYNC-1:0] sLvl, sRise, sFall;
  logic [mecsi_pkg::N_SYNC-1:0] rawIn;
  // RL16 link inputs synchronised
  assign rawIn = {oscIn, collisionPair, rxLine, tx_clock_in, rx_clock_in,
                  rx_nrz_in, collision_in, carrier_sense_in};
  mecsi_sync #(.W(mecsi_pkg::N_SYNC)) uSync (
    .clk    (clk),
    .reset  (reset),
    .asyncIn(rawIn),
    .lvl    (sLvl),
    .rise   (sRise),
    .fall   (sFall)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0]  dataCfg_q;
  logic        dcrWritten_q;
  logic [3:0]  secCfg_q;
  logic [mecsi_pkg::N_EVT-1:0] sts_q, mask_q, stsD;
  logic [9:0]  hold_q;
  logic        holdV_q;
  logic [7:0]  rxData_q;
  logic        apbWr, apbAcc;
  logic        extSel, extended_bus_option;
  mecsi_pkg::mecsi_evt_t evt;

  assign apbAcc = psel & penable & pready;
  assign apbWr  = apbAcc & pwrite;
  assign extSel = dataCfg_q[mecsi_pkg::F_EXT];
  assign extended_bus_option  = dataCfg_q[mecsi_pkg::F_EXTENDED_BUS_OPTION];

  // ----------------------------------------------------------------
  // Internal Manchester decoder
  // ----------------------------------------------------------------
  logic       crsInt_q, rxNrzInt_q, rxClkInt_q, rxClkPrev_q;
  logic [9:0] gap_q, tail_q, rxPh_q, colCnt_q;
  logic       lineEdge, midEdge, rxActive, colInt;
  assign lineEdge = sRise[mecsi_pkg::S_LINE] | sFall[mecsi_pkg::S_LINE];
  assign midEdge  = crsInt_q ? (lineEdge && gap_q >= mecsi_pkg::MIN_C)
                             : sFall[mecsi_pkg::S_LINE];

  // Edges closer than three quarters of a bit are cell boundaries.
  // RL1 carrier start and hold
  always_ff @(posedge clk) begin
    if (reset) begin
      crsInt_q   <= 1'h0;
      rxNrzInt_q <= 1'h0;
      gap_q      <= '0;
    end else if (midEdge) begin
      crsInt_q   <= 1'h1;
      rxNrzInt_q <= sRise[mecsi_pkg::S_LINE];
      gap_q      <= '0;
    end else if (!crsInt_q) begin
      gap_q <= '0;
    end else if (gap_q == mecsi_pkg::DROP_C) begin
      crsInt_q <= 1'h0;
      gap_q    <= '0;
    end else begin
      gap_q <= gap_q + 10'h001;
    end
  end

  // Recovered clock: phase restarts at each decoded bit.
  // RL10 clock tail after carrier
  assign rxActive = crsInt_q | (tail_q != '0);
  always_ff @(posedge clk) begin
    if (reset) begin
      tail_q      <= '0;
      rxPh_q      <= '0;
      rxClkInt_q  <= 1'h0;
      rxClkPrev_q <= 1'h0;
    end else begin
      if (crsInt_q) begin
        tail_q <= mecsi_pkg::TAIL_C;
      end else if (tail_q != '0) begin
        tail_q <= tail_q - 10'h001;
      end
      if (midEdge || !rxActive || rxPh_q == mecsi_pkg::BIT_C) begin
        rxPh_q <= '0;
      end else begin
        rxPh_q <= rxPh_q + 10'h001;
      end
      rxClkInt_q  <= rxActive && rxPh_q >= mecsi_pkg::HALF_C;
      rxClkPrev_q <= rxClkInt_q;
    end
  end

  // RL5 collision tone detect
  assign colInt = colCnt_q != '0;
  always_ff @(posedge clk) begin
    if (reset) begin
      colCnt_q <= '0;
    end else if (sRise[mecsi_pkg::S_CPR] | sFall[mecsi_pkg::S_CPR]) begin
      colCnt_q <= mecsi_pkg::COLW_C;
    end else if (colInt) begin
      colCnt_q <= colCnt_q - 10'h001;
    end
  end

  // RL15 transmit clock from oscillator
  logic txClkInt_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      txClkInt_q <= 1'h0;
    end else if (sRise[mecsi_pkg::S_OSC]) begin
      txClkInt_q <= ~txClkInt_q;
    end
  end

  // ----------------------------------------------------------------
  // MAC source selection
  // ----------------------------------------------------------------
  logic macCrs, macCol, macRxBit, macRxRise, txLvl, txPrev_q, txFall;
  // RL2 codec select
  assign macCrs    = extSel ? sLvl[mecsi_pkg::S_CRS] : crsInt_q;
  assign macCol    = extSel ? sLvl[mecsi_pkg::S_COL] : colInt;
  assign macRxBit  = extSel ? sLvl[mecsi_pkg::S_RXD] : rxNrzInt_q;
  assign macRxRise = extSel ? sRise[mecsi_pkg::S_RXC]
                            : rxClkInt_q & ~rxClkPrev_q;
  assign txLvl     = extSel ? sLvl[mecsi_pkg::S_TXC] : txClkInt_q;
  assign txFall    = txPrev_q & ~txLvl;

  // ----------------------------------------------------------------
  // MAC receive deserialiser
  // ----------------------------------------------------------------
  logic [7:0] rxSh_q;
  logic [2:0] rxCnt_q;
  // RL8 RL9 capture on receive clock rise
  always_ff @(posedge clk) begin
    if (reset) begin
      rxSh_q   <= '0;
      rxCnt_q  <= '0;
      rxData_q <= '0;
    end else if (!macCrs) begin
      rxCnt_q <= '0;
    end else if (macRxRise) begin
      rxSh_q  <= {macRxBit, rxSh_q[7:1]};
      rxCnt_q <= rxCnt_q + 3'h1;
      if (rxCnt_q == mecsi_pkg::RX_LAST) begin
        rxData_q <= {macRxBit, rxSh_q[7:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // MAC transmit serialiser
  // ----------------------------------------------------------------
  mecsi_pkg::mecsi_tx_t txSt_q;
  logic [7:0] txSh_q;
  logic [3:0] txCnt_q;
  logic [9:0] hbCnt_q;
  logic       txLast_q, watch_q, txNrz_q, txLoad, byteEnd;
  assign byteEnd = txSt_q == mecsi_pkg::TX_SEND && txFall
                   && txCnt_q == mecsi_pkg::TX_BITS;
  assign txLoad  = holdV_q && (txSt_q == mecsi_pkg::TX_IDLE || (byteEnd && !txLast_q));
  assign evt.rxByte    = macCrs && macRxRise && rxCnt_q == mecsi_pkg::RX_LAST;
  assign evt.txReady   = txLoad;
  // RL6 RL7 collision and heartbeat
  assign evt.collision = txSt_q == mecsi_pkg::TX_SEND && watch_q && macCol;
  assign evt.heartbeat = txSt_q == mecsi_pkg::TX_HB && macCol;
  assign evt.txDone    = byteEnd && (txLast_q || !holdV_q);

  // Data moves on the falling edge so it is stable at the rising edge.
  // An empty holding register at a byte end closes the frame early.
  // RL11 RL12 shift and enable
  always_ff @(posedge clk) begin
    if (reset) begin
      txSt_q    <= mecsi_pkg::TX_IDLE;
      txSh_q    <= '0;
      txCnt_q   <= '0;
      txLast_q  <= 1'h0;
      watch_q   <= 1'h0;
      txNrz_q   <= 1'h0;
      tx_enable <= 1'h0;
      hbCnt_q   <= '0;
      txPrev_q  <= 1'h0;
    end else begin
      txPrev_q <= txLvl;
      if (txLoad) begin
        txSh_q   <= hold_q[7:0];
        txLast_q <= hold_q[mecsi_pkg::F_LAST];
        watch_q  <= watch_q | hold_q[mecsi_pkg::F_SFD];
        txCnt_q  <= '0;
      end
      unique case (txSt_q)
        mecsi_pkg::TX_IDLE: begin
          if (txLoad) begin
            txSt_q    <= mecsi_pkg::TX_SEND;
            tx_enable <= 1'h1;
          end
        end
        mecsi_pkg::TX_SEND: begin
          if (evt.txDone) begin
            txSt_q    <= mecsi_pkg::TX_HB;
            tx_enable <= 1'h0;
            watch_q   <= 1'h0;
            hbCnt_q   <= mecsi_pkg::HBW_C;
          end else if (txFall && !byteEnd) begin
            txNrz_q <= txSh_q[0];
            txSh_q  <= {1'h0, txSh_q[7:1]};
            txCnt_q <= txCnt_q + 4'h1;
          end
        end
        mecsi_pkg::TX_HB: begin
          // RL7 heartbeat window
          if (macCol || hbCnt_q == '0) begin
            txSt_q <= mecsi_pkg::TX_IDLE;
          end else begin
            hbCnt_q <= hbCnt_q - 10'h001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB slave, one wait state on every access
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
      prdata  <= '0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'h0;
      prdata  <= '0;
      if (psel && penable && !pready) begin
        unique case (paddr)
          mecsi_pkg::A_DATA_CFG: prdata <= {30'h0000_0000, dataCfg_q};
          mecsi_pkg::A_SEC_CFG:  prdata <= {28'h000_0000, secCfg_q};
          mecsi_pkg::A_STATUS:   prdata <= {27'h000_0000, sts_q};
          mecsi_pkg::A_MASK:     prdata <= {27'h000_0000, mask_q};
          mecsi_pkg::A_TX_DATA:  prdata <= {21'h00_0000, holdV_q, hold_q};
          mecsi_pkg::A_RX_DATA:  prdata <= {21'h00_0000, tx_enable, macCol, macCrs,
                                 rxData_q};
          default:    pslverr <= 1'h1;
        endcase
      end
    end
  end

  // Configuration and holding register writes; a full holding
  // register ignores a new byte.
  always_ff @(posedge clk) begin
    if (reset) begin
      dataCfg_q    <= '0;
      dcrWritten_q <= 1'h0;
      secCfg_q     <= '0;
      mask_q       <= '0;
      hold_q       <= '0;
      holdV_q      <= 1'h0;
    end else begin
      if (apbWr && paddr == mecsi_pkg::A_DATA_CFG) begin
        dataCfg_q    <= pwdata[1:0];
        dcrWritten_q <= 1'h1;
      end
      if (apbWr && paddr == mecsi_pkg::A_SEC_CFG) begin
        secCfg_q <= pwdata[3:0];
      end
      if (apbWr && paddr == mecsi_pkg::A_MASK) begin
        mask_q <= pwdata[mecsi_pkg::N_EVT-1:0];
      end
      if (txLoad) begin
        holdV_q <= 1'h0;
      end else if (apbWr && paddr == mecsi_pkg::A_TX_DATA && !holdV_q) begin
        hold_q  <= pwdata[9:0];
        holdV_q <= 1'h1;
      end
    end
  end

  // Sticky status: a new event wins over a write-one clear.
  assign stsD = (sts_q & ~((apbWr && paddr == mecsi_pkg::A_STATUS)
                ? pwdata[mecsi_pkg::N_EVT-1:0] : '0)) | evt;
  always_ff @(posedge clk) begin
    if (reset) begin
      sts_q <= '0;
      irq   <= 1'h0;
    end else begin
      sts_q <= stsD;
      irq   <= |(stsD & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic [3:0] normO, normOe;
  assign normO  = {txNrz_q, 1'h0, rxClkInt_q, rxNrzInt_q};
  assign normOe = {1'h1, 1'h1, ~extSel, ~extSel};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gShared
      // RL13 RL14 shared pin ownership
      always_ff @(posedge clk) begin
        if (reset || !dcrWritten_q) begin
          sharedPin[gi] <= '0;
        end else if (extended_bus_option) begin
          sharedPin[gi] <= '{o: secCfg_q[gi], oe: busMaster};
        end else begin
          sharedPin[gi] <= '{o: normO[gi], oe: normOe[gi]};
        end
      end
    end
  endgenerate

  // RL3 internal signals shown on pins
  always_ff @(posedge clk) begin
    if (reset) begin
      carrierPin   <= '0;
      collisionPin <= '0;
      txClockPin   <= '0;
    end else begin
      carrierPin   <= '{o: crsInt_q, oe: ~extSel};
      collisionPin <= '{o: colInt, oe: ~extSel};
      txClockPin   <= '{o: txClkInt_q, oe: dcrWritten_q & ~extSel};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_crs_first_fall: assert property ( // RL1
    !crsInt_q && sFall[mecsi_pkg::S_LINE] |=> crsInt_q)
    else $error("Carrier did not rise on line fall.");
  a_crs_hold_end: assert property ( // RL1
    $fell(crsInt_q) |-> $past(gap_q) == mecsi_pkg::DROP_C)
    else $error("Carrier fell at the wrong time.");
  a_ext_carrier_mux: assert property ( // RL2
    extSel && !sLvl[mecsi_pkg::S_CRS] |=> rxCnt_q == '0)
    else $error("External carrier not selected.");
  a_obs_rx_clock: assert property ( // RL3
    dcrWritten_q && !extended_bus_option && !extSel |=> sharedPin[1].oe
      && sharedPin[1].o == $past(rxClkInt_q))
    else $error("Receive clock not shown on pin.");
  a_col_tone: assert property ( // RL5
    sRise[mecsi_pkg::S_CPR] |=> colInt [*8])
    else $error("Collision tone not flagged.");
  a_col_watch: assert property ( // RL6
    txSt_q == mecsi_pkg::TX_SEND && watch_q && macCol |=> sts_q[2])
    else $error("Frame collision not recorded.");
  a_hb_check: assert property ( // RL7
    txSt_q == mecsi_pkg::TX_HB && macCol |=> sts_q[3] && txSt_q == mecsi_pkg::TX_IDLE)
    else $error("Heartbeat not recorded.");
  a_rx_capture: assert property ( // RL9
    evt.rxByte |=> rxData_q[7] == $past(macRxBit))
    else $error("Receive bit not captured.");
  a_rx_tail: assert property ( // RL10
    $fell(crsInt_q) |-> ##100 rxActive)
    else $error("Receive clock stopped early.");
  a_tx_fall_only: assert property ( // RL11
    $changed(txNrz_q) |-> $past(txFall))
    else $error("Transmit data moved off the falling edge.");
  a_tx_enable: assert property ( // RL12
    tx_enable == (txSt_q == mecsi_pkg::TX_SEND))
    else $error("Transmit enable out of step.");
  a_pins_float: assert property ( // RL13
    !dcrWritten_q |=> !sharedPin[0].oe && !sharedPin[1].oe && !sharedPin[2].oe
      && !sharedPin[3].oe)
    else $error("Shared pin driven before configuration.");
  a_user_out: assert property ( // RL14
    dcrWritten_q && extended_bus_option |=> sharedPin[2].oe == $past(busMaster))
    else $error("User output drive wrong.");
  a_osc_half: assert property ( // RL15
    sRise[mecsi_pkg::S_OSC] |=> txClkInt_q != $past(txClkInt_q))
    else $error("Transmit clock not toggled.");

  c_rx_byte: cover property (evt.rxByte);
  c_frame_col: cover property (evt.collision);
  c_tx_done_hb: cover property (evt.txDone ##[1:300] evt.heartbeat);
endmodule // mecsi_top

// *** mecsi_pkg.sv ***
// Constants, register map and pin, event and state types of the codec serial interface.
package mecsi_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 4;
  localparam int BIT_NS      = 100;
  localparam int BIT_CYC     = BIT_NS / CLK_NS;
  localparam int HALF_CYC    = BIT_CYC / 2;
  localparam int MID_MIN_CYC = (3 * BIT_CYC) / 4;
  localparam int CRS_HOLD_NS = 150;
  localparam int CRS_HOLD_CYC = (CRS_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DROP_CYC    = HALF_CYC + CRS_HOLD_CYC;
  localparam int TAIL_BITS   = 5;
  localparam int TAIL_CYC    = TAIL_BITS * BIT_CYC;
  localparam int COL_WIN_NS  = 200;
  localparam int COL_WIN_CYC = COL_WIN_NS / CLK_NS;
  localparam int HB_WIN_NS   = 4000;
  localparam int HB_WIN_CYC  = HB_WIN_NS / CLK_NS;
  // Counter-width forms of the counts above.
  localparam logic [9:0] BIT_C   = 10'(BIT_CYC - 1);
  localparam logic [9:0] HALF_C  = 10'(HALF_CYC);
  localparam logic [9:0] MIN_C   = 10'(MID_MIN_CYC);
  localparam logic [9:0] DROP_C  = 10'(DROP_CYC - 1);
  localparam logic [9:0] TAIL_C  = 10'(TAIL_CYC);
  localparam logic [9:0] COLW_C  = 10'(COL_WIN_CYC);
  localparam logic [9:0] HBW_C   = 10'(HB_WIN_CYC);
  localparam logic [3:0] TX_BITS = 4'h8;
  localparam logic [2:0] RX_LAST = 3'h7;
  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] A_DATA_CFG = 12'h000;
  localparam logic [11:0] A_SEC_CFG  = 12'h004;
  localparam logic [11:0] A_STATUS   = 12'h008;
  localparam logic [11:0] A_MASK     = 12'h00C;
  localparam logic [11:0] A_TX_DATA  = 12'h010;
  localparam logic [11:0] A_RX_DATA  = 12'h014;
  localparam int F_EXTENDED_BUS_OPTION = 0;
  localparam int F_EXT   = 1;
  localparam int F_LAST  = 8;
  localparam int F_SFD   = 9;
  localparam int N_EVT   = 5;
  // ----------------------------------------------------------------
  // Synchroniser lanes
  // ----------------------------------------------------------------
  localparam int S_CRS = 0;
  localparam int S_COL = 1;
  localparam int S_RXD = 2;
  localparam int S_RXC = 3;
  localparam int S_TXC = 4;
  localparam int S_LINE = 5;
  localparam int S_CPR = 6;
  localparam int S_OSC = 7;
  localparam int N_SYNC = 8;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic o;
    logic oe;
  } mecsi_pin_t;
  typedef struct packed {
    logic txDone;
    logic heartbeat;
    logic collision;
    logic txReady;
    logic rxByte;
  } mecsi_evt_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_SEND = 3'h2,
    TX_HB   = 3'h4
  } mecsi_tx_t;
endpackage

// *** mecsi_sync.sv ***
// Two-flop synchronisers with edge detection on the synchronised level.
`timescale 1ns/1ps
module mecsi_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Asynchronous inputs and their synchronised forms
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges are flagged in the same cycle that the synchronised level changes.
  assign lvl  = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = prev_q & ~sync_q;
endmodule // mecsi_sync

// *** mecsi_codec_model.sv ***
// Behavioural model of an external Manchester codec facing the block.
`timescale 1ns/1ps
module mecsi_codec_model (
  // Link signals toward the block
  output logic      carrierSense,
  output logic      collision,
  output logic      rxData,
  output logic      rxClock,
  output logic      txClock,
  // Line side of the internal codec
  output logic      line,
  output logic      tonePair,
  output logic      osc,
  // Serial data from the block
  input  wire logic txData
);
  // Clocks stand still between frames; the transmit clock and line idle high.
  initial begin
    {carrierSense, collision, rxData, rxClock, txClock, line, tonePair, osc} = 8'h0C;
  end

  // Manchester cells: a zero falls at mid-cell, a one rises there.
  task automatic send_line(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      line = ~b[i];
      #50 line = b[i];
      #50;
    end
    line = 1'b1;
  endtask

  // Collision tone of n half periods.
  task automatic tone(input int n);
    repeat (n) begin
      #50 tonePair = ~tonePair;
    end
  endtask

  // Oscillator burst of n periods; it idles low between bursts.
  task automatic osc_run(input int n);
    repeat (n) begin
      #25 osc = 1'b1;
      #25 osc = 1'b0;
    end
  endtask

  task automatic send_byte(input logic [7:0] b);
    carrierSense = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rxData = b[i];
      #32 rxClock = 1'b1;
      #32 rxClock = 1'b0;
    end
    carrierSense = 1'b0;
    // A released line shows the inverse so a stale level cannot pass.
    rxData = ~rxData;
  endtask

  task automatic tx_frame(output logic [7:0] b);
    for (int i = 0; i < 9; i++) begin
      #32 txClock = 1'b0;
      // Collision tone in mid-frame, one bit long.
      collision = (i == 4);
      if (i < 8) begin
        #32 txClock = 1'b1;
        b[i] = txData;
      end
    end
    // The clock returns to its idle level so a later frame starts clean.
    #32 txClock = 1'b1;
    // Heartbeat pulse shortly after the frame ends.
    #368 collision = 1'b1;
    #200 collision = 1'b0;
  endtask
endmodule // mecsi_codec_model

// *** testbench.sv ***
// Self-checking bench of the codec serial interface with an external codec.
`timescale 1ns/1ps
module testbench;
  logic        clk, reset, busMaster, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        pready, pslverr, irq, txEnable, err;
  logic        crs, col, rxd, rxc, tx_shift_clock;
  logic        line, tonePair, osc, tcPrev;
  logic [7:0]  b, got;
  logic [7:0]  rxQ[$];
  int          n_mismatch, n_compared, nTxc, k0;
  mecsi_pkg::mecsi_pin_t       carrierPin, collisionPin, txClockPin;
  mecsi_pkg::mecsi_pin_t [3:0] sharedPin;

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts changes of the observed transmit clock pin.
  always @(posedge clk) begin
    tcPrev <= txClockPin.o;
    if (txClockPin.o !== tcPrev) begin
      nTxc <= nTxc + 1;
    end
  end

  mecsi_top dut (
    .clk(clk), .reset(reset), .busMaster(busMaster), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .rxLine(line), .collisionPair(tonePair), .oscIn(osc),
    .carrier_sense_in(crs), .collision_in(col), .rx_nrz_in(rxd), .rx_clock_in(rxc),
    .tx_clock_in(tx_shift_clock), .carrierPin(carrierPin), .collisionPin(collisionPin),
    .txClockPin(txClockPin), .sharedPin(sharedPin), .tx_enable(txEnable)
  );

  mecsi_codec_model codec (
    .carrierSense(crs), .collision(col), .rxData(rxd), .rxClock(rxc), .txClock(tx_shift_clock),
    .line(line), .tonePair(tonePair), .osc(osc),
    .txData(sharedPin[3].o)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Output enables: shared pins 3..0, then carrier and transmit clock.
  function automatic logic [31:0] oes();
    return {26'h0, sharedPin[3].oe, sharedPin[2].oe, sharedPin[1].oe,
            sharedPin[0].oe, carrierPin.oe, txClockPin.oe};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic test_done();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer; request held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      chk(32'h0, 32'h1, "bus timeout");
      test_done();
    end
    @(posedge clk);
  endtask

  // Main sequence.
  initial begin
    seed = 32'h0001_73E4;
    {reset, busMaster, psel, penable, pwrite} = 5'h10;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_mismatch = 0;
    n_compared = 0;
    nTxc = 0;
    cyc(8);
    reset <= 1'b0;
    cyc(2);
    chk(oes() >> 2, 32'h0, "pins before config");
    apb(1'b1, mecsi_pkg::A_DATA_CFG, 32'h0);
    cyc(2);
    chk(oes(), 32'h3F, "internal pins");
    // Internal codec: each oscillator rise toggles the transmit clock once.
    k0 = nTxc;
    codec.osc_run(6);
    cyc(8);
    chk(nTxc - k0, 32'h6, "tx clock halves osc");
    // The first line fall decodes as a zero, so the byte starts with zero.
    b = 8'(rnd()) & 8'hFE;
    codec.send_line(b);
    chk({31'h0, carrierPin.o}, 32'h1, "carrier held");
    cyc(64);
    chk({31'h0, carrierPin.o}, 32'h0, "carrier dropped");
    apb(1'b0, mecsi_pkg::A_RX_DATA, 32'h0);
    chk({24'h0, rd[7:0]}, {24'h0, b}, "internal rx byte");
    codec.tone(8);
    cyc(4);
    chk({31'h0, collisionPin.o}, 32'h1, "collision tone");
    cyc(64);
    chk({31'h0, collisionPin.o}, 32'h0, "collision idle");
    apb(1'b0, 12'h0F0, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    b = 8'(rnd());
    apb(1'b1, mecsi_pkg::A_SEC_CFG, {28'h0, b[3:0]});
    apb(1'b1, mecsi_pkg::A_DATA_CFG, 32'h1);
    cyc(2);
    chk(oes() >> 2, 32'h0, "user pins idle");
    busMaster <= 1'b1;
    cyc(3);
    chk({24'h0, sharedPin}, {24'h0, b[3], 1'b1, b[2], 1'b1, b[1], 1'b1, b[0], 1'b1},
        "user");
    busMaster <= 1'b0;
    apb(1'b1, mecsi_pkg::A_DATA_CFG, 32'h2);
    cyc(2);
    chk(oes(), 32'h30, "external pins");
    for (int i = 0; i < 3; i++) begin
      rxQ.push_back(8'(rnd()));
      codec.send_byte(rxQ[$]);
      cyc(4);
      apb(1'b0, mecsi_pkg::A_RX_DATA, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, rxQ.pop_front()}, "rx byte");
    end
    chk({31'h0, irq}, 32'h0, "masked irq");
    apb(1'b1, mecsi_pkg::A_MASK, 32'h1F);
    cyc(2);
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b1, mecsi_pkg::A_STATUS, 32'h1F);
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    b = 8'(rnd());
    apb(1'b1, mecsi_pkg::A_TX_DATA, {22'h0, 2'h3, b});
    cyc(2);
    chk({31'h0, txEnable}, 32'h1, "tx enable up");
    codec.tx_frame(got);
    cyc(8);
    chk({24'h0, got}, {24'h0, b}, "tx byte");
    chk({31'h0, txEnable}, 32'h0, "tx enable down");
    apb(1'b0, mecsi_pkg::A_STATUS, 32'h0);
    chk(rd, 32'h1E, "tx events");
    test_done();
  end
endmodule // testbench
